/* File: rtl/bbw_mem.sv */
`timescale 1ns/1ns
module bbw_mem
    import bbw_pkg::*;
#(
    parameter int AW = BBW_MEM_AW,
    parameter int DEPTH = BBW_MEM_DEPTH
)
(
    input wire logic clock,
    input wire logic [AW-1:0] addr,
    input wire logic wr_en,
    input wire logic [1:0] byte_en,
    input wire logic [17:0] wr_data,
    output logic [17:0] rd_data_ff
);
    logic [8:0] lo_mem [DEPTH];
    logic [8:0] hi_mem [DEPTH];

    if (DEPTH > (1 << AW))
    begin
        $error("bbw_mem depth exceeds address range");
    end

    // Each byte keeps its own parity-error flag so a byte write only marks
    // the lane it wrote.
    always_ff @(posedge clock)
    begin
        if (wr_en && byte_en[0])
            lo_mem[addr] <= {wr_data[16], wr_data[7:0]};
        if (wr_en && byte_en[1])
            hi_mem[addr] <= {wr_data[17], wr_data[15:8]};
        rd_data_ff <= {hi_mem[addr][8], lo_mem[addr][8],
                       hi_mem[addr][7:0], lo_mem[addr][7:0]};
    end
endmodule

/* File: rtl/bbw_pkg.sv */
package bbw_pkg;

    localparam int BBW_AW = 22;
    localparam int BBW_DW = 16;
    localparam int BBW_IO_BITS = 13;
    localparam int BBW_MEM_DEPTH = 1024;
    localparam int BBW_MEM_AW = 10;

    localparam int CLK_PERIOD_NS = 100;
    // Data may become valid no later than this after the acknowledge.
    localparam int DATA_VALID_MAX_NS = 125;
    localparam int DATA_VALID_CYC =
        (DATA_VALID_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (DATA_VALID_MAX_NS / CLK_PERIOD_NS);
    // Acknowledge drops at most this long before the read data go away.
    localparam int ACK_DROP_LEAD_NS = 100;
    localparam int ACK_DROP_LEAD_CYC =
        (ACK_DROP_LEAD_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (ACK_DROP_LEAD_NS / CLK_PERIOD_NS);

    localparam logic [12:0] IO_BASE_RST = 13'h0000;
    localparam logic [21:0] MEM_BASE_RST = 22'h000000;

    typedef enum logic [4:0] {
        BBW_IDLE = 5'h01,
        BBW_SEL = 5'h02,
        BBW_RD = 5'h04,
        BBW_WR = 5'h08,
        BBW_DONE = 5'h10
    } bbw_state_t;

endpackage

/* File: rtl/bbw_slave.sv */
`timescale 1ns/1ns
module bbw_slave
    import bbw_pkg::*;
#(
    parameter int MEM_AW = BBW_MEM_AW,
    parameter logic [12:0] IO_BASE = IO_BASE_RST,
    parameter logic [21:0] MEM_BASE = MEM_BASE_RST,
    parameter bit IS_IO = 1'b0,
    parameter bit MEM_IN_IO_PAGE = 1'b0
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [21:0] adl_in,
    output logic [21:0] adl_out_ff,
    output logic adl_oe_n_ff,
    input wire logic cycle_frame,
    input wire logic read_strobe,
    input wire logic write_strobe,
    input wire logic write_byte_select,
    input wire logic io_page_select,
    output logic slave_acknowledge_ff,
    output logic selected_ff
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);

    logic [21:0] adl_s1_ff, adl_s2_ff;
    logic [3:0] ctl_s1_ff, ctl_s2_ff;
    logic frame_q_ff;
    bbw_state_t state_ff, nxt_state;
    logic [21:0] addr_ff;
    logic is_write_ff;
    logic [$clog2(DATA_VALID_CYC+2)-1:0] dv_cnt_ff;
    logic [17:0] rd_data;

    // The io decode needs at least one page bit above the word address.
    if (MEM_AW < 1 || MEM_AW + 1 >= BBW_IO_BITS)
    begin
        $error("bbw_slave memory window does not fit the io page");
    end

    // Both stages are flops; only the second stage feeds any logic.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            adl_s1_ff <= 22'h000000;
            adl_s2_ff <= 22'h000000;
            ctl_s1_ff <= 4'h0;
            ctl_s2_ff <= 4'h0;
        end
        else
        begin
            adl_s1_ff <= adl_in;
            adl_s2_ff <= adl_s1_ff;
            ctl_s1_ff <= {cycle_frame, read_strobe, write_strobe,
                          io_page_select};
            ctl_s2_ff <= ctl_s1_ff;
        end
    end

    wire frame_s = ctl_s2_ff[3];
    wire rd_s = ctl_s2_ff[2];
    wire wr_s = ctl_s2_ff[1];
    wire io_s = ctl_s2_ff[0];
    wire frame_rise = frame_s && !frame_q_ff;

    // Write select takes the same two stages as the frame, so the value
    // latched on the frame edge is the one set up with the address.
    logic wbs_s1_ff, wbs_s2_ff;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wbs_s1_ff <= 1'b0;
            wbs_s2_ff <= 1'b0;
        end
        else
        begin
            wbs_s1_ff <= write_byte_select;
            wbs_s2_ff <= wbs_s1_ff;
        end
    end

    // Io page decode skips bits 21:13.
    wire io_hit = io_s &&
        (adl_s2_ff[12:MEM_AW+1] == IO_BASE[12:MEM_AW+1]);
    // Memory ignores the io page unless told otherwise.
    // Bit 16 asks for a forced parity error, so it takes no part in the
    // decode; otherwise that request could never reach this memory.
    wire mem_hit = (!io_s || MEM_IN_IO_PAGE) &&
        (adl_s2_ff[21:17] == MEM_BASE[21:17]) &&
        (adl_s2_ff[15:MEM_AW+1] == MEM_BASE[15:MEM_AW+1]);
    wire addr_hit = IS_IO ? io_hit : mem_hit;

    wire rd_req = (state_ff == BBW_SEL) && rd_s && !is_write_ff;
    // Read-modify-write: a write strobe may follow the read in one frame.
    wire wr_req = (state_ff == BBW_SEL) && wr_s;
    wire wr_commit = (state_ff == BBW_WR) && !wr_s;
    wire byte_mode = wbs_s2_ff && is_write_ff;
    // Byte lane from latched address bit 0; a word write hits both.
    wire [1:0] lanes = !byte_mode ? 2'h3 : (addr_ff[0] ? 2'h2 : 2'h1);
    // Latched bit 16 writes a forced parity error; it drives bits 17 and 16.
    wire [17:0] wr_word = {addr_ff[16], addr_ff[16], adl_s2_ff[15:0]};

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            BBW_IDLE:
                if (frame_rise && addr_hit)
                    nxt_state = BBW_SEL;
            BBW_SEL:
                if (!frame_s)
                    nxt_state = BBW_IDLE;
                else if (rd_req)
                    nxt_state = BBW_RD;
                else if (wr_req)
                    nxt_state = BBW_WR;
            BBW_RD:
                if (!rd_s)
                    nxt_state = BBW_DONE;
            BBW_WR:
                if (!wr_s)
                    nxt_state = BBW_SEL;
            BBW_DONE:
                nxt_state = frame_s ? BBW_SEL : BBW_IDLE;
            default:
                nxt_state = BBW_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= BBW_IDLE;
            frame_q_ff <= 1'b0;
            addr_ff <= 22'h000000;
            is_write_ff <= 1'b0;
            dv_cnt_ff <= '0;
            slave_acknowledge_ff <= 1'b0;
            adl_out_ff <= 22'h000000;
            adl_oe_n_ff <= 1'b1;
            selected_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            frame_q_ff <= frame_s;
            // Address and direction captured on the frame edge only.
            if (frame_rise)
            begin
                addr_ff <= adl_s2_ff;
                is_write_ff <= wbs_s2_ff;
            end
            selected_ff <= (nxt_state != BBW_IDLE);
            // Acknowledge and data go out together, inside the 125 ns bound,
            // because the memory read data are ready before the strobe.
            slave_acknowledge_ff <= (nxt_state == BBW_RD) ||
                                    (nxt_state == BBW_WR);
            if (nxt_state == BBW_RD)
            begin
                adl_out_ff <= {4'h0, rd_data};
                adl_oe_n_ff <= 1'b0;
            end
            // Data leave one cycle after acknowledge falls.
            else if (state_ff == BBW_DONE || state_ff == BBW_IDLE)
            begin
                adl_oe_n_ff <= 1'b1;
            end
            // The counter saturates so that a long strobe cannot wrap it.
            if (state_ff != BBW_RD)
                dv_cnt_ff <= '0;
            else if (!(&dv_cnt_ff))
                dv_cnt_ff <= dv_cnt_ff + 1'b1;
        end
    end

    bbw_mem #(
        .AW(MEM_AW),
        .DEPTH(1 << MEM_AW)
    ) u_mem (
        .clock(clock),
        .addr(addr_ff[MEM_AW:1]),
        .wr_en(wr_commit),
        .byte_en(lanes),
        .wr_data(wr_word),
        .rd_data_ff(rd_data)
    );

    sequence frame_edge_s;
        frame_rise && addr_hit && state_ff == BBW_IDLE;
    endsequence

    sequence read_ack_s;
        rd_req ##1 slave_acknowledge_ff;
    endsequence

    sel_on_frame_a: assert property (
        frame_edge_s |=> ##1 selected_ff)
        else $error("slave not selected after frame");
    sel_drop_a: assert property (
        !frame_s && state_ff == BBW_SEL |=> ##1 !selected_ff)
        else $error("slave stayed selected after frame");
    read_ack_a: assert property (
        read_ack_s |-> !adl_oe_n_ff)
        else $error("read data not driven with acknowledge");
    ack_before_data_a: assert property (
        $fell(slave_acknowledge_ff) && state_ff == BBW_DONE
        |-> !adl_oe_n_ff ##1 adl_oe_n_ff)
        else $error("read data not removed one cycle after acknowledge");
    ack_hold_a: assert property (
        state_ff == BBW_RD && rd_s |=> slave_acknowledge_ff)
        else $error("acknowledge dropped while strobe held");
    write_commit_a: assert property (
        state_ff == BBW_WR && !wr_s |=> !slave_acknowledge_ff)
        else $error("acknowledge kept after write strobe fell");
    byte_lane_a: assert property (
        wr_commit && byte_mode |-> lanes == (addr_ff[0] ? 2'h2 : 2'h1))
        else $error("byte lane mismatch");
    io_ignore_a: assert property (
        frame_rise && io_s && !IS_IO && !MEM_IN_IO_PAGE
        |=> state_ff == BBW_IDLE)
        else $error("memory answered io page address");
    dv_bound_a: assert property (
        state_ff == BBW_RD && dv_cnt_ff >= DATA_VALID_CYC
        |-> !adl_oe_n_ff && adl_out_ff == {4'h0, rd_data})
        else $error("read data not valid in time");
endmodule

/* File: tb/backplane_bus_word_cycles_bench.sv */
`timescale 1ns/1ns
module backplane_bus_word_cycles_bench;
    logic clock;
    logic nrst;
    logic [21:0] m_adl;
    logic [21:0] s_adl;
    logic [21:0] adl_bus;
    logic s_oe_n;
    logic frame;
    logic rd_stb;
    logic wr_stb;
    logic wbs;
    logic io;
    logic ack;
    logic sel;
    logic [17:0] rd;
    logic ok;
    int mismatches;
    int cmp_count;

    assign adl_bus = s_oe_n ? m_adl : s_adl;

    bbw_slave u_bbw_slave (.clock(clock), .nrst(nrst), .adl_in(adl_bus),
        .adl_out_ff(s_adl), .adl_oe_n_ff(s_oe_n), .cycle_frame(frame),
        .read_strobe(rd_stb), .write_strobe(wr_stb),
        .write_byte_select(wbs), .io_page_select(io),
        .slave_acknowledge_ff(ack), .selected_ff(sel));

    bbw_master_model u_bbw_master_model (.clock(clock), .bus(adl_bus),
        .ack(ack), .adl(m_adl), .frame(frame), .rd_stb(rd_stb),
        .wr_stb(wr_stb), .wbs(wbs), .io(io));

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic t_word;
        u_bbw_master_model.cycle(22'h10, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0,
            16'hA5C3, rd, ok);
        chk_bit(ok, 1'h1);
        u_bbw_master_model.cycle(22'h10, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0,
            16'h0, rd, ok);
        chk(rd, 18'h0A5C3);
        $display("word test done");
    endtask

    // The unwanted byte of each write differs, so a wrong lane shows.
    task automatic t_byte;
        u_bbw_master_model.cycle(22'h11, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1,
            16'h7EAA, rd, ok);
        u_bbw_master_model.cycle(22'h10, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1,
            16'h5511, rd, ok);
        u_bbw_master_model.cycle(22'h10, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0,
            16'h0, rd, ok);
        chk(rd, 18'h07E11);
        $display("byte test done");
    endtask

    task automatic t_parity;
        u_bbw_master_model.cycle(22'h10020, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0,
            16'h1234, rd, ok);
        u_bbw_master_model.cycle(22'h20, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0,
            16'h0, rd, ok);
        chk(rd, 18'h31234);
        u_bbw_master_model.cycle(22'h20, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0,
            16'h4321, rd, ok);
        u_bbw_master_model.cycle(22'h20, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0,
            16'h0, rd, ok);
        chk(rd, 18'h04321);
        $display("parity test done");
    endtask

    // The io page must go unanswered and leave the memory deselected.
    task automatic t_io;
        fork
            u_bbw_master_model.cycle(22'h10, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0,
                16'h0, rd, ok);
            begin
                repeat (8) @(negedge clock);
                chk_bit(sel, 1'h0);
            end
        join
        chk_bit(ok, 1'h0);
        $display("io test done");
    endtask

    task automatic t_rmw;
        fork
            u_bbw_master_model.cycle(22'h10, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0,
                16'hBEEF, rd, ok);
            begin
                repeat (8) @(negedge clock);
                chk_bit(sel, 1'h1);
            end
        join
        chk(rd, 18'h07E11);
        chk_bit(sel, 1'h0);
        u_bbw_master_model.cycle(22'h10, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0,
            16'h0, rd, ok);
        chk(rd, 18'h0BEEF);
        $display("rmw test done");
    endtask

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial
    begin
        #300000;
        mismatches++;
        tally_and_finish;
    end

    initial
    begin
        mismatches = 0;
        cmp_count = 0;
        nrst = 1'b0;
        repeat (6) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        t_word;
        t_byte;
        t_parity;
        t_io;
        t_rmw;
        tally_and_finish;
    end
endmodule

/* File: tb/bbw_master_model.sv */
`timescale 1ns/1ns
module bbw_master_model
(
    input wire logic clock,
    input wire logic [21:0] bus,
    input wire logic ack,
    output logic [21:0] adl,
    output logic frame,
    output logic rd_stb,
    output logic wr_stb,
    output logic wbs,
    output logic io
);
    initial
    begin
        adl = 22'h000000;
        frame = 1'b0;
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        wbs = 1'b0;
        io = 1'b0;
    end

    // A missing acknowledge aborts after a bounded wait.
    task automatic wait_ack(input logic lvl, output logic ok);
        int n;
        n = 0;
        while (ack !== lvl && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        ok = (ack === lvl);
    endtask

    task automatic cycle(input logic [21:0] a, input logic is_io,
        input logic w_sel, input logic do_rd, input logic do_wr,
        input logic byte_w,
        input logic [15:0] wd, output logic [17:0] rd, output logic ok);
        logic ok2;
        rd = 18'h00000;
        ok = 1'b1;
        @(negedge clock);
        adl = a;
        io = is_io;
        wbs = w_sel;
        @(negedge clock);
        frame = 1'b1;
        @(negedge clock);
        // Stale address lines are inverted so a late sample shows.
        adl = ~a;
        repeat (3) @(negedge clock);
        if (do_rd)
        begin
            rd_stb = 1'b1;
            wait_ack(1'b1, ok);
            repeat (2) @(negedge clock);
            rd = bus[17:0];
            rd_stb = 1'b0;
            wait_ack(1'b0, ok2);
            repeat (2) @(negedge clock);
        end
        if (do_wr && ok)
        begin
            adl = {6'h00, wd};
            wbs = byte_w;
            repeat (2) @(negedge clock);
            wr_stb = 1'b1;
            wait_ack(1'b1, ok);
            repeat (2) @(negedge clock);
            wr_stb = 1'b0;
            @(negedge clock);
            adl = ~adl;
            wait_ack(1'b0, ok2);
            @(negedge clock);
        end
        frame = 1'b0;
        repeat (4) @(negedge clock);
    endtask
endmodule
